// file: irq_mask_pkg.sv
// Package with register map, field positions, reset values and timing for the interrupt block.
package irq_mask_pkg;

  // ***************************************************************
  // Register map (byte addresses on the Wishbone bus)
  // ***************************************************************
  localparam int unsigned ADDR_W      = 6;
  localparam logic [5:0]  ADDR_MASK1  = 6'h00;
  localparam logic [5:0]  ADDR_CFG2   = 6'h04;
  localparam logic [5:0]  ADDR_CFG3   = 6'h08;
  localparam logic [5:0]  ADDR_START  = 6'h0C;
  localparam logic [5:0]  ADDR_STAT1  = 6'h10;
  localparam logic [5:0]  ADDR_STAT2  = 6'h14;
  localparam logic [5:0]  ADDR_MASK2  = 6'h18;
  localparam logic [5:0]  ADDR_TTAG   = 6'h1C;
  localparam logic [5:0]  ADDR_CLR1   = 6'h20;
  localparam logic [5:0]  ADDR_CLR2   = 6'h24;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int unsigned CFG2_UNMASKED_BIT = 15;
  localparam int unsigned CFG2_PARITY_BIT   = 14;
  localparam int unsigned CFG2_AUTOCLR_BIT  = 4;
  localparam int unsigned CFG2_LEVEL_BIT    = 3;
  localparam int unsigned CFG3_EXT_BIT      = 15;
  localparam int unsigned START_INTRST_BIT  = 2;

  // ***************************************************************
  // Reset values and active event sets
  // ***************************************************************
  localparam logic [15:0] REG_RST      = 16'h0000;
  localparam logic [14:0] ACTIVE1_BASE = 15'h00FF;
  localparam logic [14:0] ACTIVE1_EXT  = 15'h7FFF;
  localparam logic [14:0] ACTIVE2_EXT  = 15'h7FFE;
  localparam logic [14:0] NONE15       = 15'h0000;
  localparam logic [15:0] TTAG_MAX     = 16'hFFFF;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam real         CLK_FREQ_MHZ      = 200.0;
  localparam real         TX_TIMEOUT_US     = 660.5;
  localparam int unsigned TX_TIMEOUT_CYCLES = int'($ceil(TX_TIMEOUT_US * CLK_FREQ_MHZ));

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef struct packed {
    logic extMode;
    logic unmaskedCapture;
    logic parityEn;
    logic autoClear;
    logic levelMode;
  } irq_cfg_t;

  typedef struct packed {
    logic parityErr;
    logic cmdStackRoll;
    logic monCmdRoll;
    logic monDataRoll;
    logic handshakeFail;
    logic ctlRetry;
    logic addrParityErr;
    logic circBufRoll;
    logic ctlWordEom;
    logic endOfFrame;
    logic formatErr;
    logic patternTrig;
    logic endOfMsg;
  } ev_in_t;

endpackage

// file: tx_watchdog.sv
// Transmitter watchdog that flags an over-long transmission.
`timescale 1ns/1ps
module tx_watchdog
  import irq_mask_pkg::*;
#(
  parameter int unsigned LIMIT = TX_TIMEOUT_CYCLES
)
(
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic txActive,
  input  wire logic enable,
  output logic      timeoutPulse
);

  localparam int unsigned CW = $clog2(LIMIT + 1);

  logic [CW-1:0] cnt_ff;

  // Count transmit cycles; stopping at the limit keeps the pulse to one per transmission.
  always_ff @(posedge sys_clk)
  begin
    if (srst || !txActive || !enable)
      cnt_ff <= '0;
    else if (cnt_ff != CW'(LIMIT))
      cnt_ff <= cnt_ff + 1'b1;
  end

  // One-cycle pulse when the transmission outlasts the limit.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      timeoutPulse <= 1'b0;
    else
      timeoutPulse <= txActive && enable && (cnt_ff == CW'(LIMIT - 1));
  end

endmodule

// file: interrupt_mask_and_request.sv
// Interrupt mask, status latching and request output logic with a Wishbone register slave.
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module interrupt_mask_and_request
  import irq_mask_pkg::*;
#(
  parameter int unsigned TX_TIMEOUT = TX_TIMEOUT_CYCLES
)
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire ev_in_t      evIn1,
  input  wire logic [14:1] evIn2,
  input  wire logic        timeTagTick,
  input  wire logic        txActive,
  input  wire logic        ctlTermMode,
  output logic             intReqN,
  output logic             irqLevel
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  logic [15:0] mask1_ff;
  logic [15:0] mask2_ff;
  logic [15:0] cfg2_ff;
  logic [15:0] cfg3_ff;
  logic [14:0] stat1_ff;
  logic [14:0] stat2_ff;
  logic [15:0] timeTag_ff;
  logic        intFlag_ff;
  logic        sr2Owed_ff;
  logic        ack_ff;
  logic [31:0] rdData_ff;
  logic        intReqN_ff;
  logic        irqLevel_ff;

  irq_cfg_t    cfg;
  logic        capAll;
  logic [14:0] active1;
  logic [14:0] active2;
  logic [14:0] mask1Eff;
  logic [14:0] mask2Eff;
  logic [14:0] events1;
  logic [14:0] events2;
  logic [14:0] set1;
  logic [14:0] set2;
  logic [14:0] clr1;
  logic [14:0] clr2;
  logic [14:0] pending1;
  logic [14:0] pending2;
  logic        anyPend;
  logic        newReq;
  logic        levelReq;
  logic        ttagRoll;
  logic        txTimeout;
  logic        busReq;
  logic        commit;
  logic        wrCommit;
  logic        rdCommit;
  logic [15:0] wrData;
  logic [15:0] lane;
  logic        intResetWr;

  // ***************************************************************
  // Wishbone slave
  // ***************************************************************

  // Accesses are answered one cycle after the request; writes and read side effects
  // happen on the edge where the master samples ack, so a held request acts once.
  assign busReq   = wb_cyc_i && wb_stb_i;
  assign commit   = busReq && ack_ff;
  assign wrCommit = commit && wb_we_i;
  assign rdCommit = commit && !wb_we_i;
  assign lane     = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wrData   = wb_dat_i[15:0];

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      ack_ff <= 1'b0;
    else
      ack_ff <= busReq && !ack_ff;
  end

  // Read data is captured as ack rises; unmapped offsets read as zero.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      rdData_ff <= '0;
    else if (busReq && !ack_ff)
    begin
      case (wb_adr_i)
        ADDR_MASK1: rdData_ff <= {17'h00000, mask1_ff[14:0]};
        ADDR_MASK2: rdData_ff <= {17'h00000, mask2_ff[14:0]};
        ADDR_CFG2:  rdData_ff <= {16'h0000, cfg2_ff};
        ADDR_CFG3:  rdData_ff <= {16'h0000, cfg3_ff};
        ADDR_STAT1: rdData_ff <= {17'h00000, stat1_ff};
        ADDR_STAT2: rdData_ff <= {17'h00000, stat2_ff[14:1], |stat1_ff};
        ADDR_TTAG:  rdData_ff <= {16'h0000, timeTag_ff};
        default:    rdData_ff <= '0;
      endcase
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdData_ff;

  // ***************************************************************
  // Software registers
  // ***************************************************************

  // Mask registers clear on reset so nothing requests until software opts in.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      mask1_ff <= REG_RST;
    else if (wrCommit && wb_adr_i == ADDR_MASK1)
      mask1_ff <= ((mask1_ff & ~lane) | (wrData & lane)) & 16'h7FFF;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      mask2_ff <= REG_RST;
    else if (wrCommit && wb_adr_i == ADDR_MASK2)
      mask2_ff <= ((mask2_ff & ~lane) | (wrData & lane)) & 16'h7FFE;
  end

  // Configuration registers: only the interrupt fields steer this block.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      cfg2_ff <= REG_RST;
    else if (wrCommit && wb_adr_i == ADDR_CFG2)
      cfg2_ff <= (cfg2_ff & ~lane) | (wrData & lane);
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      cfg3_ff <= REG_RST;
    else if (wrCommit && wb_adr_i == ADDR_CFG3)
      cfg3_ff <= (cfg3_ff & ~lane) | (wrData & lane);
  end

  // The start/reset register is a command strobe and holds no state.
  assign intResetWr = wrCommit && (wb_adr_i == ADDR_START) && wb_sel_i[0]
                      && wrData[START_INTRST_BIT];

  assign cfg.extMode         = cfg3_ff[CFG3_EXT_BIT];
  assign cfg.unmaskedCapture = cfg2_ff[CFG2_UNMASKED_BIT];
  assign cfg.parityEn        = cfg2_ff[CFG2_PARITY_BIT];
  assign cfg.autoClear       = cfg2_ff[CFG2_AUTOCLR_BIT];
  assign cfg.levelMode       = cfg2_ff[CFG2_LEVEL_BIT];

  // ***************************************************************
  // Event sources
  // ***************************************************************

  // Time tag counter; the wrap tick is the rollover event.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      timeTag_ff <= '0;
    else if (timeTagTick)
      timeTag_ff <= timeTag_ff + 16'h0001;
  end

  assign ttagRoll = timeTagTick && (timeTag_ff == TTAG_MAX);

  tx_watchdog #(
    .LIMIT (TX_TIMEOUT)
  ) u_tx_watchdog (
    .sys_clk      (sys_clk),
    .srst         (srst),
    .txActive     (txActive),
    .enable       (ctlTermMode),
    .timeoutPulse (txTimeout)
  );

  // Event vector in mask bit order; parity errors only count when checking is on.
  assign events1 = {evIn1.parityErr && cfg.parityEn && cfg.extMode,
                    txTimeout,
                    evIn1.cmdStackRoll,
                    evIn1.monCmdRoll,
                    evIn1.monDataRoll,
                    evIn1.handshakeFail,
                    evIn1.ctlRetry,
                    evIn1.addrParityErr,
                    ttagRoll,
                    evIn1.circBufRoll,
                    evIn1.ctlWordEom,
                    evIn1.endOfFrame,
                    evIn1.formatErr,
                    evIn1.patternTrig,
                    evIn1.endOfMsg};
  assign events2 = {evIn2, 1'b0};

  // ***************************************************************
  // Mode-dependent masking
  // ***************************************************************

  // Full capture needs both the extended mode and the unmasked-capture bit.
  assign capAll   = cfg.extMode && cfg.unmaskedCapture;
  assign active1  = capAll ? ACTIVE1_EXT : ACTIVE1_BASE;
  assign active2  = capAll ? ACTIVE2_EXT : NONE15;
  assign mask1Eff = cfg.extMode ? (mask1_ff[14:0] & active1)
                                : {7'h00, mask1_ff[7:0]};
  assign mask2Eff = mask2_ff[14:0] & active2;

  // Latch gating: status 1 latches masked-in events only and status 2 latches nothing, unless full capture ignores the mask.
  assign set1 = events1 & active1 & (capAll ? ACTIVE1_EXT : mask1Eff);
  assign set2 = events2 & active2;

  // ***************************************************************
  // Status registers
  // ***************************************************************

  // Reads clear only with auto clear; write-one clears always work. A new event in
  // the clearing cycle survives because the set term is applied last.
  assign clr1 = ((rdCommit && wb_adr_i == ADDR_STAT1 && cfg.autoClear) ? ACTIVE1_EXT : NONE15)
              | ((wrCommit && wb_adr_i == ADDR_CLR1) ? wrData[14:0] : NONE15);
  assign clr2 = ((rdCommit && wb_adr_i == ADDR_STAT2 && cfg.autoClear) ? ACTIVE2_EXT : NONE15)
              | ((wrCommit && wb_adr_i == ADDR_CLR2) ? wrData[14:0] : NONE15);

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      stat1_ff <= '0;
    else
      stat1_ff <= (stat1_ff & ~clr1) | set1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      stat2_ff <= '0;
    else
      stat2_ff <= ((stat2_ff & ~clr2) | set2) & ACTIVE2_EXT;
  end

  // ***************************************************************
  // Request generation
  // ***************************************************************

  // The request is always gated by the mask, even when capture ignores it.
  assign pending1 = stat1_ff & mask1Eff;
  assign pending2 = stat2_ff & mask2Eff;
  assign anyPend  = (|pending1) || (|pending2);
  assign newReq   = (|(set1 & mask1Eff)) || (|(set2 & mask2Eff));

  // Status 2 must be read before the level can drop while it holds unmasked events.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      sr2Owed_ff <= 1'b0;
    else if (|(set2 & mask2Eff))
      sr2Owed_ff <= 1'b1;
    else if (rdCommit && wb_adr_i == ADDR_STAT2)
      sr2Owed_ff <= 1'b0;
  end

  // Latched level for the no-auto-clear case; the reset command loses to a new event.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      intFlag_ff <= 1'b0;
    else if (newReq)
      intFlag_ff <= 1'b1;
    else if (intResetWr && !sr2Owed_ff)
      intFlag_ff <= 1'b0;
  end

  // With auto clear the level follows pending status, so a status read releases it.
  assign levelReq = cfg.autoClear ? anyPend : intFlag_ff;

  // Active-low request pin: one-cycle pulse per new event, or a held level.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      intReqN_ff <= 1'b1;
    else
      intReqN_ff <= !(cfg.levelMode ? levelReq : newReq);
  end

  // Plain active-high level for a system interrupt controller.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      irqLevel_ff <= 1'b0;
    else
      irqLevel_ff <= anyPend;
  end

  assign intReqN  = intReqN_ff;
  assign irqLevel = irqLevel_ff;

endmodule

// file: irq_mask_asserts.sv
// Checker of bus, reset and request timing at the interrupt block ports.
`timescale 1ns/1ps
module irq_mask_asserts
  import irq_mask_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire ev_in_t      evIn1,
  input wire logic        intReqN,
  input wire logic        irqLevel
);
  logic [15:0] maskTrk_ff;
  logic        lvlTrk_ff;

  // Shadows of host writes, so that events can be tied to their requests.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      maskTrk_ff <= REG_RST;
    else if (wb_ack_o && wb_we_i && wb_adr_i == ADDR_MASK1)
      maskTrk_ff <= wb_dat_i[15:0];
  end

  // Level or pulse form, as last written by the host.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      lvlTrk_ff <= 1'b0;
    else if (wb_ack_o && wb_we_i && wb_adr_i == ADDR_CFG2)
      lvlTrk_ff <= wb_dat_i[CFG2_LEVEL_BIT];
  end

  // ********
  // Properties
  // ********
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
  sequence s_idle; !wb_cyc_i [*3] ##0 !intReqN; endsequence
  property p_ack; s_req |=> s_ans; endproperty
  property p_hi0; wb_ack_o |-> wb_dat_o[31:16] == 16'h0000; endproperty
  property p_rsv; wb_ack_o && !wb_we_i && wb_adr_i == ADDR_MASK1 |-> !wb_dat_o[15]; endproperty
  property p_unmap; wb_ack_o && !wb_we_i && wb_adr_i > ADDR_CLR2 |-> wb_dat_o == 32'h0; endproperty
  property p_rst; disable iff (1'b0) srst |=> intReqN && !irqLevel && !wb_ack_o; endproperty
  // The status bit shows one cycle after the event, and the registered level a cycle later.
  property p_evt; evIn1.endOfMsg && maskTrk_ff[0] |-> ##2 irqLevel; endproperty
  // A pulse comes straight from the new event; a level waits for the latched flag, or with auto clear the status bit, first.
  property p_evtp; evIn1.endOfMsg && maskTrk_ff[0] && !lvlTrk_ff |=> !intReqN; endproperty
  property p_evtl; evIn1.endOfMsg && maskTrk_ff[0] && lvlTrk_ff |-> ##2 !intReqN; endproperty
  property p_pulse; !lvlTrk_ff && $fell(intReqN) |=> intReqN; endproperty
  property p_hold; lvlTrk_ff throughout s_idle |=> !intReqN; endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");
  a_hi0: assert property (p_hi0) else $error("upper read data not zero");
  a_rsv: assert property (p_rsv) else $error("reserved mask bit reads one");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  a_evt: assert property (p_evt) else $error("masked event gave no request");
  a_evtp: assert property (p_evtp) else $error("pulse request missing after event");
  a_evtl: assert property (p_evtl) else $error("level request missing after event");
  a_pulse: assert property (p_pulse) else $error("pulse longer than a cycle");
  a_hold: assert property (p_hold) else $error("level request dropped alone");
endmodule

// file: irq_host_model.sv
// Host-side model that counts requests seen on the active-low interrupt line.
`timescale 1ns/1ps
module irq_host_model
(
  input  wire logic  sys_clk,
  input  wire logic  srst,
  input  wire logic  intReqN,
  output int unsigned reqCount
);
  logic prevN_ff;

  // An edge-sensitive host sees one request per high-to-low step of the line.
  always_ff @(posedge sys_clk)
  begin
    prevN_ff <= srst ? 1'b1 : intReqN;
    if (srst)
      reqCount <= 0;
    else if (prevN_ff && !intReqN)
      reqCount <= reqCount + 1;
  end
endmodule

// file: interrupt_mask_and_request_tb_top.sv
// Self-checking bench for the interrupt mask and request block.
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    samples_checked++; \
    if ((a) !== (e)) \
    begin \
      bad_count++; \
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (e)); \
    end \
  end
module interrupt_mask_and_request_tb_top
  import irq_mask_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        srst    = 1'b1;
  logic        wbCyc   = 1'b0;
  logic        wbStb   = 1'b0;
  logic        wbWe    = 1'b0;
  logic [5:0]  wbAdr   = 6'h00;
  logic [3:0]  wbSel   = 4'h0;
  logic [31:0] wbDat   = 32'h0;
  logic [31:0] datO;
  logic [31:0] rdData;
  logic        ackO;
  ev_in_t      evIn1   = '0;
  logic [14:1] evIn2   = '0;
  logic        tick    = 1'b0;
  logic        txAct   = 1'b0;
  logic        ctlTerm = 1'b0;
  logic        intReqN;
  logic        irqLevel;
  int unsigned reqCount;
  int          bad_count = 0;
  int          samples_checked = 0;

  always #2.5 sys_clk = ~sys_clk;

  // The watchdog limit is shortened so the timeout event fits the run.
  interrupt_mask_and_request #(.TX_TIMEOUT(20)) dut_u (.sys_clk(sys_clk), .srst(srst),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDat), .wb_dat_o(datO), .wb_ack_o(ackO), .evIn1(evIn1), .evIn2(evIn2),
    .timeTagTick(tick), .txActive(txAct), .ctlTermMode(ctlTerm), .intReqN(intReqN),
    .irqLevel(irqLevel));
  irq_host_model host_u (.sys_clk(sys_clk), .srst(srst), .intReqN(intReqN),
    .reqCount(reqCount));

  // ********
  // Bus and event tasks
  // ********
  // One classic cycle; the request is held until ack is sampled high.
  task automatic wbx(input logic w, input logic [5:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= w;
    wbAdr <= a;
    wbSel <= 4'hF;
    wbDat <= {16'h0000, d};
    @(posedge sys_clk);
    while (ackO !== 1'b1) @(posedge sys_clk);
    rdData = datO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    wbx(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    wbx(1'b0, a, 16'h0000);
    `CHK(rdData, {16'h0000, e})
  endtask
  // Events last one cycle, since a held level latches again each cycle.
  task automatic ev(input ev_in_t v1, input logic [14:1] v2);
    @(posedge sys_clk);
    evIn1 <= v1;
    evIn2 <= v2;
    @(posedge sys_clk);
    evIn1 <= '0;
    evIn2 <= '0;
  endtask
  task automatic chkN(input logic e);
    repeat (4) @(posedge sys_clk);
    `CHK(intReqN, e)
  endtask
  task automatic stop_test();
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // A hang is cut short well after the longest expected run.
  initial
  begin
    #400000;
    bad_count++;
    stop_test();
  end

  // ********
  // Scenarios
  // ********
  initial
  begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    rd(ADDR_MASK1, 16'h0000);
    `CHK(intReqN, 1'b1)
    wr(ADDR_MASK1, 16'hFFFF);
    rd(ADDR_MASK1, 16'h7FFF);
    rd(6'h3C, 16'h0000);
    wr(ADDR_MASK1, 16'h0101);
    ev(ev_in_t'(13'h0001), '0);
    chkN(1'b1);
    `CHK(reqCount, 1)
    `CHK(irqLevel, 1'b1)
    ev(ev_in_t'(13'h0084), '0);
    rd(ADDR_STAT1, 16'h0001);
    `CHK(reqCount, 1)
    wr(ADDR_CLR1, 16'hFFFF);
    wr(ADDR_CFG2, 16'h0008);
    ev(ev_in_t'(13'h0001), '0);
    chkN(1'b0);
    wr(ADDR_START, 16'h0004);
    chkN(1'b1);
    wr(ADDR_CFG2, 16'h0018);
    chkN(1'b0);
    rd(ADDR_STAT1, 16'h0001);
    chkN(1'b1);
    wr(ADDR_CFG3, 16'h8000);
    wr(ADDR_MASK1, 16'h0000);
    wr(ADDR_MASK2, 16'h0008);
    wr(ADDR_CFG2, 16'hC008);
    ctlTerm <= 1'b1;
    ev(ev_in_t'(13'h1FFF), '0);
    txAct <= 1'b1;
    repeat (25) @(posedge sys_clk);
    txAct <= 1'b0;
    tick  <= 1'b1;
    repeat (65536) @(posedge sys_clk);
    tick <= 1'b0;
    chkN(1'b1);
    `CHK(irqLevel, 1'b0)
    ev('0, 14'h3FFF);
    chkN(1'b0);
    wr(ADDR_START, 16'h0004);
    chkN(1'b0);
    rd(ADDR_STAT2, 16'h7FFF);
    wr(ADDR_START, 16'h0004);
    chkN(1'b1);
    `CHK(irqLevel, 1'b1)
    rd(ADDR_STAT1, 16'h7FFF);
    stop_test();
  end
endmodule

bind interrupt_mask_and_request irq_mask_asserts chk_u (.sys_clk, .srst, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .evIn1, .intReqN, .irqLevel);
